// *** dxs_map.vh ***
// Constants for the steered-oscillator channel logic.
// Assumes a 40 MHz system clock and a host writing control words byte by byte.
`ifndef DXS_MAP_VH
`define DXS_MAP_VH
`define DXS_FCW_W 42
`define DXS_FCW_REG_W 48
`define DXS_PCW_W 32
`define DXS_TMR_W 16
`define DXS_TRIG_W 16
`define DXS_FCW_BYTES 6
`define DXS_PCW_BYTES 4
`define DXS_CLK_HZ 40000000
`define DXS_TICK_MS 1
`define DXS_MODE_TRACK 2'h0
`define DXS_MODE_EXTLF 2'h1
`define DXS_MODE_WFREQ 2'h2
`define DXS_MODE_WPHASE 2'h3
`define DXS_SEL_FCW 2'h0
`define DXS_SEL_PCW 2'h1
`define DXS_SEL_STEP 2'h2
`endif

// *** dxs_word_assembler.v ***
// Byte-wise word assembler: collects bytes in a shadow, commits on final byte.
// Assumes byte writes arrive as single-cycle strobes on the system clock.
`timescale 1ns/1ps
module dxs_word_assembler #(
    parameter W = 48,
    parameter NB = 6
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Byte write
    input wire wr_in,
    input wire [7:0] data_in,
    input wire [3:0] idx_in,
    // Committed word
    output reg [W-1:0] word_out,
    output reg commit_out
);
    localparam [3:0] NB_L = NB;
    reg [NB*8-1:0] shadow_q;
    wire last;
    assign last = (idx_in == NB_L - 4'h1);
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shadow_q <= {NB*8{1'b0}};
            word_out <= {W{1'b0}};
            commit_out <= 1'b0;
        end else begin
            commit_out <= 1'b0;
            if (wr_in && idx_in < NB_L) begin
                shadow_q[idx_in*8 +: 8] <= data_in;
                if (last) begin
                    // Whole word moves at once so steering never sees a torn value
                    word_out <= {data_in, shadow_q[NB*8-9:0]};
                    commit_out <= 1'b1;
                end
            end
        end
    end
endmodule // dxs_word_assembler

// *** dxs_channel.v ***
// One steered-oscillator channel: picks the divider steering word per mode.
// Assumes loop filter, phase detector and output dividers are outside.
`timescale 1ns/1ps
`include "dxs_map.vh"
module dxs_channel #(
    parameter CH = 0,
    parameter TICK_CYC = `DXS_CLK_HZ / 1000 * `DXS_TICK_MS
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Host byte writes
    input wire wr_in,
    input wire [1:0] wr_sel_in,
    input wire [3:0] wr_idx_in,
    input wire [7:0] wr_data_in,
    // Control
    input wire [1:0] mode_in,
    input wire [`DXS_TMR_W-1:0] phase_timer_ms_in,
    input wire phase_timer_en_in,
    input wire phase_timer_hold_in,
    input wire [`DXS_TRIG_W-1:0] trig_inc_in,
    input wire [`DXS_TRIG_W-1:0] trig_dec_in,
    input wire trig_wr_in,
    input wire pin_inc_in,
    input wire pin_dec_in,
    input wire coarse_wr_in,
    input wire [15:0] coarse_phase_in,
    // From internal loop
    input wire [`DXS_FCW_W-1:0] loop_fcw_in,
    input wire loop_update_in,
    input wire [`DXS_PCW_W-1:0] phase_err_in,
    input wire all_refs_lost_in,
    // Steering and status
    output reg [`DXS_FCW_W-1:0] divider_steer_out,
    output reg [`DXS_PCW_W-1:0] filter_phase_out,
    output reg [`DXS_PCW_W-1:0] phase_err_read_out,
    output reg [15:0] coarse_phase_out,
    output reg coarse_jump_out,
    output reg holdover_out,
    output reg [`DXS_FCW_W-1:0] cum_fcw_out
);
    localparam [`DXS_FCW_W-1:0] MAXV = {1'b0, {(`DXS_FCW_W-1){1'b1}}};
    localparam [`DXS_FCW_W-1:0] MINV = {1'b1, {(`DXS_FCW_W-1){1'b0}}};
    localparam [31:0] TICK_N = TICK_CYC;

    wire [`DXS_FCW_REG_W-1:0] fcw_word;
    wire fcw_commit;
    wire [`DXS_PCW_W-1:0] pcw_word;
    wire pcw_commit;
    wire [`DXS_FCW_REG_W-1:0] step_word;

    ////////////////////////////////////////////////////////////////////////
    dxs_word_assembler #(.W(`DXS_FCW_REG_W), .NB(`DXS_FCW_BYTES)) u_fcw (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_in && wr_sel_in == `DXS_SEL_FCW),
        .data_in(wr_data_in),
        .idx_in(wr_idx_in),
        .word_out(fcw_word),
        .commit_out(fcw_commit)
    );
    // Phase word has its own four-byte shadow so byte order maps straight onto bits
    dxs_word_assembler #(.W(`DXS_PCW_W), .NB(`DXS_PCW_BYTES)) u_pcw (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_in && wr_sel_in == `DXS_SEL_PCW),
        .data_in(wr_data_in),
        .idx_in(wr_idx_in),
        .word_out(pcw_word),
        .commit_out(pcw_commit)
    );
    dxs_word_assembler #(.W(`DXS_FCW_REG_W), .NB(`DXS_FCW_BYTES)) u_step (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_in && wr_sel_in == `DXS_SEL_STEP),
        .data_in(wr_data_in),
        .idx_in(wr_idx_in),
        .word_out(step_word),
        .commit_out()
    );

    ////////////////////////////////////////////////////////////////////////
    // Pins cross domains: two flops before use, then rising-edge detect
    reg [1:0] inc_sync_q;
    reg [1:0] dec_sync_q;
    reg inc_prev_q;
    reg dec_prev_q;
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            inc_sync_q <= 2'h0;
            dec_sync_q <= 2'h0;
            inc_prev_q <= 1'b0;
            dec_prev_q <= 1'b0;
        end else begin
            inc_sync_q <= {inc_sync_q[0], pin_inc_in};
            dec_sync_q <= {dec_sync_q[0], pin_dec_in};
            inc_prev_q <= inc_sync_q[1];
            dec_prev_q <= dec_sync_q[1];
        end
    end
    wire pin_inc = inc_sync_q[1] & ~inc_prev_q;
    wire pin_dec = dec_sync_q[1] & ~dec_prev_q;
    wire do_inc = (trig_wr_in & trig_inc_in[CH]) | pin_inc;
    wire do_dec = (trig_wr_in & trig_dec_in[CH]) | pin_dec;

    ////////////////////////////////////////////////////////////////////////
    // Cumulative word, saturating one bit wider
    reg [`DXS_FCW_W-1:0] cum_d;
    reg [`DXS_FCW_W:0] sum;
    wire [`DXS_FCW_W-1:0] step = step_word[`DXS_FCW_W-1:0];
    always @* begin
        cum_d = cum_fcw_out;
        sum = {cum_fcw_out[`DXS_FCW_W-1], cum_fcw_out};
        if (fcw_commit)
            cum_d = fcw_word[`DXS_FCW_W-1:0];
        else if (do_inc != do_dec) begin
            if (do_inc)
                sum = sum + {step[`DXS_FCW_W-1], step};
            else
                sum = sum - {step[`DXS_FCW_W-1], step};
            if (sum[`DXS_FCW_W] != sum[`DXS_FCW_W-1])
                cum_d = sum[`DXS_FCW_W] ? MINV : MAXV;
            else
                cum_d = sum[`DXS_FCW_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase word timer: millisecond prescaler and 16-bit down count
    reg [31:0] pre_q;
    reg [`DXS_TMR_W-1:0] ms_q;
    reg tmr_run_q;
    reg [`DXS_PCW_W-1:0] pcw_q;
    reg pcw_hold_q;
    wire tick = (pre_q == TICK_N - 32'h1);
    wire expire = tmr_run_q && tick && ms_q == {`DXS_TMR_W{1'b0}};
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_q <= 32'h0;
            ms_q <= {`DXS_TMR_W{1'b0}};
            tmr_run_q <= 1'b0;
            pcw_q <= {`DXS_PCW_W{1'b0}};
            pcw_hold_q <= 1'b0;
            cum_fcw_out <= {`DXS_FCW_W{1'b0}};
        end else begin
            cum_fcw_out <= cum_d;
            pre_q <= (tick || pcw_commit) ? 32'h0 : pre_q + 32'h1;
            if (pcw_commit) begin
                pcw_q <= pcw_word;
                // An expiry in the same cycle as a new word still sets holdover
                pcw_hold_q <= expire && phase_timer_hold_in;
                ms_q <= phase_timer_ms_in - 16'h1;
                tmr_run_q <= phase_timer_en_in && phase_timer_ms_in != 16'h0;
            end else if (expire) begin
                tmr_run_q <= 1'b0;
                if (phase_timer_hold_in)
                    pcw_hold_q <= 1'b1;
                else
                    pcw_q <= {`DXS_PCW_W{1'b0}};
            end else if (tmr_run_q && tick)
                ms_q <= ms_q - 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Steering selection per mode
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            divider_steer_out <= {`DXS_FCW_W{1'b0}};
            filter_phase_out <= {`DXS_PCW_W{1'b0}};
            phase_err_read_out <= {`DXS_PCW_W{1'b0}};
            coarse_phase_out <= 16'h0;
            coarse_jump_out <= 1'b0;
            holdover_out <= 1'b0;
        end else begin
            coarse_jump_out <= coarse_wr_in;
            if (coarse_wr_in)
                coarse_phase_out <= coarse_phase_in;
            holdover_out <= 1'b0;
            case (mode_in)
            `DXS_MODE_TRACK: begin
                filter_phase_out <= phase_err_in;
                if (all_refs_lost_in)
                    holdover_out <= 1'b1;
                else if (loop_update_in)
                    divider_steer_out <= loop_fcw_in;
            end
            `DXS_MODE_EXTLF: begin
                if (loop_update_in)
                    phase_err_read_out <= phase_err_in;
                divider_steer_out <= cum_fcw_out;
            end
            `DXS_MODE_WFREQ: begin
                // Word-level update only; the divider absorbs it on its own edge
                divider_steer_out <= cum_fcw_out;
            end
            default: begin
                filter_phase_out <= pcw_q;
                holdover_out <= pcw_hold_q;
                if (loop_update_in && !pcw_hold_q)
                    divider_steer_out <= loop_fcw_in;
            end
            endcase
        end
    end
endmodule // dxs_channel

// *** dxs_channel_monitor.sv ***
// Port checker for one steered-oscillator channel.
// Assumes the top module dxs_channel and its CH parameter.
`timescale 1ns/1ps
module dxs_channel_monitor #(parameter CH = 0) (
    // Clock, reset and stimulus
    input wire ref_clk_in,
    input wire rst_in,
    input wire wr_in,
    input wire trig_wr_in,
    input wire [15:0] trig_inc_in,
    input wire [15:0] trig_dec_in,
    input wire pin_inc_in,
    input wire pin_dec_in,
    input wire coarse_wr_in,
    input wire [15:0] coarse_phase_in,
    input wire [1:0] mode_in,
    input wire all_refs_lost_in,
    // Watched outputs
    input wire [41:0] divider_steer_out,
    input wire [15:0] coarse_phase_out,
    input wire coarse_jump_out,
    input wire holdover_out,
    input wire [41:0] cum_fcw_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Pin steps trail by the synchroniser, so quiet spans eight cycles
    reg [7:0] act_q;
    wire act = wr_in | trig_wr_in | pin_inc_in | pin_dec_in;
    always @(posedge ref_clk_in or posedge rst_in)
        if (rst_in)
            act_q <= 8'h00;
        else
            act_q <= {act_q[6:0], act};
    sequence wfreq_run; (mode_in == 2'h2)[*3]; endsequence
    sequence trig_alone; trig_wr_in && !wr_in && !pin_inc_in && !pin_dec_in && act_q == 8'h00;
    endsequence
    reset_zero_a: assert property ($fell(rst_in) |-> cum_fcw_out == 42'h0)
        else $error("word not clear after reset");
    jump_now_a: assert property (coarse_wr_in |=> coarse_jump_out)
        else $error("coarse jump missing");
    jump_value_a: assert property (coarse_wr_in |=> coarse_phase_out == $past(coarse_phase_in))
        else $error("coarse phase wrong");
    steer_follow_a: assert property (wfreq_run |-> divider_steer_out == $past(cum_fcw_out))
        else $error("steering not the written word");
    freq_hold_a: assert property (wfreq_run ##0 (act_q == 8'h00 && !act) |=> $stable(divider_steer_out))
        else $error("steering moved without write");
    step_cancel_a: assert property (trig_alone ##0 (trig_inc_in[CH] && trig_dec_in[CH])
        |=> $stable(cum_fcw_out)) else $error("opposed steps not cancelled");
    step_other_a: assert property (trig_alone ##0 !(trig_inc_in[CH] || trig_dec_in[CH])
        |=> $stable(cum_fcw_out)) else $error("unselected channel stepped");
    refs_hold_a: assert property ((mode_in == 2'h0 && all_refs_lost_in)[*4] |-> holdover_out)
        else $error("no holdover on lost inputs");
endmodule // dxs_channel_monitor
bind dxs_channel dxs_channel_monitor #(.CH(CH)) u_mon (.*);

// *** dxs_host_model.sv ***
// Host model: writes control words byte by byte, low byte first.
// Assumes callers sit on the falling clock edge.
`timescale 1ns/1ps
module dxs_host_model (
    // Clock
    input wire ref_clk_in,
    // Byte write
    output reg wr_out = 1'b0,
    output reg [1:0] sel_out = 2'h0,
    output reg [3:0] idx_out = 4'h0,
    output reg [7:0] data_out = 8'h00
);
    task put(input [1:0] sel, input [47:0] w, input [3:0] n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(negedge ref_clk_in);
                wr_out = 1'b1;
                sel_out = sel;
                idx_out = i[3:0];
                data_out = w[8*i +: 8];
            end
            @(negedge ref_clk_in);
            wr_out = 1'b0;
            data_out = ~data_out; // Released bus must not keep the last byte
        end
    endtask
    task put_fcw(input [41:0] f, input [3:0] n);
        put(2'h0, {{6{f[41]}}, f}, n);
    endtask
endmodule // dxs_host_model

// *** dxs_channel_tb.sv ***
// Self-checking bench for one steered-oscillator channel.
// Assumes 40 MHz clock; the millisecond tick is shortened to 4 cycles.
`timescale 1ns/1ps
module dxs_channel_tb;
    reg clk = 1'b0, rst = 1'b1, ten = 1'b0, thold = 1'b0, twr = 1'b0, pinc = 1'b0;
    reg pdec = 1'b0, cwr = 1'b0, lupd = 1'b0, lost = 1'b0;
    reg [1:0] mode = 2'h2;
    reg [15:0] tinc = 16'h0, tdec = 16'h0, cph = 16'h1234;
    reg [41:0] lfcw = 42'h2aa;
    reg [31:0] perr = 32'h8000_0001;
    wire wr, cj, hold;
    wire [1:0] sel;
    wire [3:0] idx;
    wire [7:0] dat;
    wire [41:0] steer, cum;
    wire [31:0] fph, prd;
    wire [15:0] cpo;
    integer fails = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    dxs_host_model host (.ref_clk_in(clk), .wr_out(wr), .sel_out(sel), .idx_out(idx),
        .data_out(dat));
    dxs_channel #(.CH(0), .TICK_CYC(4)) uut (.ref_clk_in(clk), .rst_in(rst), .wr_in(wr),
        .wr_sel_in(sel), .wr_idx_in(idx), .wr_data_in(dat), .mode_in(mode),
        .phase_timer_ms_in(16'h0002), .phase_timer_en_in(ten), .phase_timer_hold_in(thold),
        .trig_inc_in(tinc), .trig_dec_in(tdec), .trig_wr_in(twr), .pin_inc_in(pinc),
        .pin_dec_in(pdec), .coarse_wr_in(cwr), .coarse_phase_in(cph), .loop_fcw_in(lfcw),
        .loop_update_in(lupd), .phase_err_in(perr), .all_refs_lost_in(lost),
        .divider_steer_out(steer), .filter_phase_out(fph), .phase_err_read_out(prd),
        .coarse_phase_out(cpo), .coarse_jump_out(cj), .holdover_out(hold), .cum_fcw_out(cum));
    task chk(input [41:0] got, input [41:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task trig(input [15:0] i, input [15:0] d);
        begin
            tinc = i;
            tdec = d;
            twr = 1'b1;
            tick(1);
            twr = 1'b0;
            tick(9);
        end
    endtask
    task t_freq;
        begin
            host.put_fcw(42'h3ff_ffff_fffb, 4'd6);
            tick(4);
            chk(steer, 42'h3ff_ffff_fffb);
            host.put_fcw(42'h123, 4'd5);
            tick(8);
            chk(steer, 42'h3ff_ffff_fffb);
            host.put(2'h2, 48'h10, 4'd6);
            host.put_fcw(42'h100, 4'd6);
            tick(4);
            trig(16'h1, 16'h0);
            chk(cum, 42'h110);
            trig(16'h0, 16'h1);
            chk(cum, 42'h100);
            trig(16'h1, 16'h1);
            chk(cum, 42'h100);
            trig(16'h2, 16'h0);
            chk(cum, 42'h100);
            trig(16'hffff, 16'h0);
            trig(16'hffff, 16'h0);
            chk(cum, 42'h120);
            pinc = 1'b1;
            tick(6);
            chk(cum, 42'h130);
            pinc = 1'b0;
            pdec = 1'b1;
            tick(6);
            chk(cum, 42'h120);
            pdec = 1'b0;
            host.put_fcw(42'h1ff_ffff_fff8, 4'd6);
            tick(4);
            trig(16'h1, 16'h0);
            chk(cum, 42'h1ff_ffff_ffff);
            chk(steer, 42'h1ff_ffff_ffff);
        end
    endtask
    task t_coarse;
        begin
            cwr = 1'b1;
            tick(1);
            cwr = 1'b0;
            chk(cj, 1'b1);
            chk(cpo, 16'h1234);
            tick(1);
            chk(cj, 1'b0);
        end
    endtask
    task t_loop;
        begin
            mode = 2'h0;
            lupd = 1'b1;
            tick(1);
            lupd = 1'b0;
            lost = 1'b1;
            tick(5);
            chk(steer, 42'h2aa);
            chk(hold, 1'b1);
            lost = 1'b0;
            mode = 2'h1;
            lupd = 1'b1;
            tick(1);
            lupd = 1'b0;
            tick(5);
            chk(prd, perr);
            host.put_fcw(42'h77, 4'd6);
            tick(4);
            chk(steer, 42'h77);
        end
    endtask
    task t_phase;
        begin
            mode = 2'h3;
            host.put(2'h1, 48'hffff_fff0, 4'd4);
            tick(20);
            chk(fph, 32'hffff_fff0);
            lupd = 1'b1;
            tick(1);
            lupd = 1'b0;
            chk(steer, 42'h2aa);
            ten = 1'b1;
            host.put(2'h1, 48'h40, 4'd4);
            tick(14);
            chk(fph, 32'h0);
            thold = 1'b1;
            host.put(2'h1, 48'h20, 4'd4);
            tick(14);
            chk(hold, 1'b1);
            lfcw = 42'h155;
            lupd = 1'b1;
            tick(1);
            lupd = 1'b0;
            chk(steer, 42'h2aa);
        end
    endtask
    task conclude;
        begin
            $display("Comparisons %0d, mismatches %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Whole run needs well under 1000 cycles; allow four times that
    initial begin
        #(4000 * 25);
        fails = fails + 1;
        conclude;
    end
    initial begin
        tick(16);
        rst = 1'b0;
        chk(cum, 42'h0);
        t_freq;
        t_coarse;
        t_loop;
        t_phase;
        conclude;
    end
endmodule // dxs_channel_tb
